// >>> mbs_pkg.sv
// constants and crc helper for the function handler link
package mbs_pkg;
   localparam logic [7:0]  FN_READ    = 8'h03;
   localparam logic [7:0]  FN_WRITE1  = 8'h06;
   localparam logic [7:0]  FN_DIAG    = 8'h08;
   localparam logic [7:0]  FN_WRITEN  = 8'h10;
   localparam logic [7:0]  FN_LOG     = 8'h46;
   localparam logic [7:0]  ERR_FLAG   = 8'h80;
   localparam logic [7:0]  BCAST_ADDR = 8'h00;
   localparam logic [7:0]  EXC_FUNC   = 8'h01;
   localparam logic [7:0]  EXC_VALUE  = 8'h03;
   localparam logic [7:0]  EXC_FAIL   = 8'h04;
   localparam logic [15:0] CRC_INIT   = 16'hffff;
   localparam logic [15:0] CRC_POLY   = 16'ha001;
   localparam int          BUF_BYTES  = 32;
   localparam logic [4:0]  MAX_REGS   = 5'h08;
   localparam int          FIFO_DEPTH = 16;
   localparam int          FIFO_WIDTH = 9;

   // one byte through the reflected crc16
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0]  b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage

// >>> mbs_link_if.sv
// byte stream link between the master end and the slave end
`timescale 1ns/100ps
interface mbs_link_if;
   logic       m2s_valid;
   logic       m2s_ready;
   logic [7:0] m2s_data;
   logic       m2s_last;
   logic       s2m_valid;
   logic       s2m_ready;
   logic [7:0] s2m_data;
   logic       s2m_last;

   modport master (output m2s_valid, m2s_data, m2s_last, s2m_ready,
                   input  m2s_ready, s2m_valid, s2m_data, s2m_last);
   modport slave  (input  m2s_valid, m2s_data, m2s_last, s2m_ready,
                   output m2s_ready, s2m_valid, s2m_data, s2m_last);
endinterface

// >>> mbs_fifo.sv
// synchronous valid/ready fifo
`timescale 1ns/100ps
module mbs_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_srst,
   // fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // drain side
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign o_in_ready  = (count != (AW+1)'(DEPTH));
   assign o_out_valid = (count != '0);
   assign o_out_data  = mem[rd_ptr];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop) count <= count + 1'b1;
         else if (pop && !push) count <= count - 1'b1;
      end
   end
endmodule // mbs_fifo

// >>> mbs_slave.sv
// slave end: frame check, function decode, register access, reply
`timescale 1ns/100ps
module mbs_slave (
   // clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   // link to master
   mbs_link_if.slave        lnk,
   // station address
   input  wire logic [7:0]  i_own_addr,
   // holding register port
   output logic             o_reg_req,
   output logic             o_reg_we,
   output logic [15:0]      o_reg_addr,
   output logic [15:0]      o_reg_wdata,
   input  wire logic        i_reg_ack,
   input  wire logic        i_reg_err,
   input  wire logic [15:0] i_reg_rdata
);
   typedef enum logic [2:0] {S_RX, S_CHECK, S_EXEC, S_LOAD, S_TX} mbs_st_e;
   typedef enum logic [2:0] {A_DROP, A_ERR, A_EXEC, A_ECHO, A_LOG} mbs_act_e;

   mbs_st_e     state;
   mbs_act_e    act;
   logic [7:0]  exc;
   logic [7:0]  rx_buf [mbs_pkg::BUF_BYTES];
   logic [7:0]  tx_buf [mbs_pkg::BUF_BYTES];
   logic [5:0]  rx_len;
   logic        rx_ovf;
   logic [15:0] rx_crc;
   logic        f_valid;
   logic [8:0]  f_data;
   logic        f_pop;
   logic [7:0]  func;
   logic        bcast;
   logic [15:0] req_start;
   logic [15:0] req_n;
   logic        op_read;
   logic        op_multi;
   logic        no_reply;
   logic [4:0]  n_regs;
   logic [4:0]  k;
   logic [15:0] acc_cnt;
   logic [5:0]  tx_len;
   logic [5:0]  tx_pos;
   logic [7:0]  tx_data;
   logic [15:0] tx_crc;
   logic [15:0] next_tx_crc;
   logic        reg_done;
   logic        tx_go;

   mbs_fifo #(
      .WIDTH (mbs_pkg::FIFO_WIDTH),
      .DEPTH (mbs_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_srst      (i_srst),
      .i_in_valid  (lnk.m2s_valid),
      .i_in_data   ({lnk.m2s_last, lnk.m2s_data}),
      .o_in_ready  (lnk.m2s_ready),
      .o_out_valid (f_valid),
      .o_out_data  (f_data),
      .i_out_ready (state == S_RX)
   );

   assign f_pop     = f_valid && (state == S_RX);
   assign func      = rx_buf[1];
   assign bcast     = (rx_buf[0] == mbs_pkg::BCAST_ADDR);
   assign req_start = {rx_buf[2], rx_buf[3]};
   assign req_n     = {rx_buf[4], rx_buf[5]};
   assign reg_done  = o_reg_req && i_reg_ack;

   // receive: buffer the frame, run the crc over every byte incl trailer
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         rx_len <= '0;
         rx_ovf <= 1'b0;
         rx_crc <= mbs_pkg::CRC_INIT;
      end else if (f_pop) begin
         if (rx_len == 6'(mbs_pkg::BUF_BYTES)) rx_ovf <= 1'b1;
         else rx_len <= rx_len + 1'b1;
         rx_crc <= mbs_pkg::crc_step(rx_crc, f_data[7:0]);
      end else if (state == S_CHECK) begin
         rx_len <= '0;
         rx_ovf <= 1'b0;
         rx_crc <= mbs_pkg::CRC_INIT;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (f_pop && rx_len != 6'(mbs_pkg::BUF_BYTES)) begin
         rx_buf[rx_len[4:0]] <= f_data[7:0];
      end
   end

   // decode; a clean frame leaves a zero crc residue over its trailer
   always_comb begin
      act = A_DROP;
      exc = mbs_pkg::EXC_FUNC;
      if (rx_crc != 16'h0000 || rx_ovf || rx_len < 6'h04) begin
         act = A_DROP;
      end else if (rx_buf[0] != i_own_addr && !bcast) begin
         act = A_DROP;
      end else begin
         unique case (func)
            mbs_pkg::FN_READ, mbs_pkg::FN_WRITEN: begin
               if (req_n == 16'h0000 || req_n > {11'h000, mbs_pkg::MAX_REGS}
                   || (func == mbs_pkg::FN_WRITEN
                       && {10'h000, rx_len} < 16'h0009 + {req_n[14:0], 1'b0}))
               begin
                  act = A_ERR;
                  exc = mbs_pkg::EXC_VALUE;
               end else begin
                  act = A_EXEC;
               end
               if (func == mbs_pkg::FN_READ && bcast) act = A_DROP;
            end
            mbs_pkg::FN_WRITE1: act = A_EXEC;
            mbs_pkg::FN_DIAG:   act = A_ECHO;
            mbs_pkg::FN_LOG:    act = A_LOG;
            default: begin
               act = A_ERR;
               exc = mbs_pkg::EXC_FUNC;
            end
         endcase
      end
   end

   // sequencing
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         state    <= S_RX;
         op_read  <= 1'b0;
         op_multi <= 1'b0;
         no_reply <= 1'b0;
         n_regs   <= '0;
         k        <= '0;
         tx_len   <= '0;
      end else begin
         unique case (state)
            S_RX: if (f_pop && f_data[8]) state <= S_CHECK;
            S_CHECK: begin
               no_reply <= bcast;
               op_read  <= (func == mbs_pkg::FN_READ);
               op_multi <= (func != mbs_pkg::FN_WRITE1);
               n_regs   <= (func == mbs_pkg::FN_WRITE1) ? 5'h01 : req_n[4:0];
               k        <= '0;
               unique case (act)
                  A_DROP: state <= S_RX;
                  A_ERR: begin
                     tx_len <= 6'h03;
                     state  <= bcast ? S_RX : S_LOAD;
                  end
                  A_EXEC: begin
                     tx_len <= (func == mbs_pkg::FN_READ)
                               ? 6'h03 + {req_n[4:0], 1'b0} : 6'h06;
                     state  <= S_EXEC;
                  end
                  A_ECHO: begin
                     tx_len <= rx_len - 6'h02;
                     state  <= bcast ? S_RX : S_LOAD;
                  end
                  A_LOG: begin
                     tx_len <= 6'h04;
                     state  <= bcast ? S_RX : S_LOAD;
                  end
                  default: state <= S_RX;
               endcase
            end
            S_EXEC: if (reg_done) begin
               if (i_reg_err) begin
                  tx_len <= 6'h03;
                  state  <= no_reply ? S_RX : S_LOAD;
               end else begin
                  k <= k + 1'b1;
                  if (k + 1'b1 == n_regs) state <= no_reply ? S_RX : S_LOAD;
               end
            end
            S_LOAD: state <= S_TX;
            S_TX: if (tx_go && tx_pos == tx_len + 6'h01) state <= S_RX;
         endcase
      end
   end

   // holding register access, one request at a time
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_reg_req   <= 1'b0;
         o_reg_we    <= 1'b0;
         o_reg_addr  <= '0;
         o_reg_wdata <= '0;
      end else if (reg_done) begin
         o_reg_req <= 1'b0;
      end else if (state == S_EXEC && !o_reg_req && k != n_regs) begin
         o_reg_req   <= 1'b1;
         o_reg_we    <= !op_read;
         o_reg_addr  <= req_start + {11'h000, k};
         o_reg_wdata <= op_multi
                        ? {rx_buf[5'h07 + {k[3:0], 1'b0}],
                           rx_buf[5'h08 + {k[3:0], 1'b0}]}
                        : req_n;
      end
   end

   // registers that succeeded in the last exchange
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         acc_cnt <= '0;
      end else if (state == S_EXEC && reg_done) begin
         acc_cnt <= {11'h000, k} + {15'h0000, !i_reg_err};
      end
   end

   // reply image
   always_ff @(posedge i_sys_clk) begin
      if (state == S_CHECK) begin
         tx_buf[0] <= rx_buf[0];
         tx_buf[1] <= (act == A_ERR) ? (func | mbs_pkg::ERR_FLAG)
                                     : func;
         unique case (act)
            A_ERR: tx_buf[2] <= exc;
            A_ECHO: begin
               for (int i = 2; i < mbs_pkg::BUF_BYTES; i++) begin
                  tx_buf[i] <= rx_buf[i];
               end
            end
            A_LOG: begin
               tx_buf[2] <= acc_cnt[15:8];
               tx_buf[3] <= acc_cnt[7:0];
            end
            A_EXEC: begin
               tx_buf[2] <= (func == mbs_pkg::FN_READ)
                            ? {req_n[6:0], 1'b0} : rx_buf[2];
               tx_buf[3] <= rx_buf[3];
               tx_buf[4] <= rx_buf[4];
               tx_buf[5] <= rx_buf[5];
            end
            default: ;
         endcase
      end else if (state == S_EXEC && reg_done) begin
         if (i_reg_err) begin
            tx_buf[1] <= func | mbs_pkg::ERR_FLAG;
            tx_buf[2] <= mbs_pkg::EXC_FAIL;
         end else if (op_read) begin
            tx_buf[5'h03 + {k[3:0], 1'b0}] <= i_reg_rdata[15:8];
            tx_buf[5'h04 + {k[3:0], 1'b0}] <= i_reg_rdata[7:0];
         end
      end
   end

   // transmit image then crc low, crc high
   assign tx_go          = (state == S_TX) && lnk.s2m_ready;
   assign next_tx_crc    = mbs_pkg::crc_step(tx_crc, tx_data);
   assign lnk.s2m_valid  = (state == S_TX);
   assign lnk.s2m_data   = tx_data;
   assign lnk.s2m_last   = (state == S_TX) && (tx_pos == tx_len + 6'h01);

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tx_pos  <= '0;
         tx_data <= '0;
         tx_crc  <= mbs_pkg::CRC_INIT;
      end else if (state == S_LOAD) begin
         tx_pos  <= '0;
         tx_data <= tx_buf[0];
         tx_crc  <= mbs_pkg::CRC_INIT;
      end else if (tx_go) begin
         tx_pos <= tx_pos + 1'b1;
         if (tx_pos < tx_len) tx_crc <= next_tx_crc;
         if (tx_pos + 6'h01 < tx_len) tx_data <= tx_buf[5'(tx_pos + 6'h01)];
         else if (tx_pos + 6'h01 == tx_len) tx_data <= next_tx_crc[7:0];
         else tx_data <= tx_crc[15:8];
      end
   end
endmodule // mbs_slave

// >>> mbs_master.sv
// master end: crc append on requests, crc check on replies
`timescale 1ns/100ps
module mbs_master (
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_srst,
   // link to slave
   mbs_link_if.master      lnk,
   // request bytes from user, without crc
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_tx_last,
   output logic            o_tx_ready,
   output logic            o_tx_refused,
   // reply bytes to user, crc included
   output logic            o_rx_valid,
   output logic [7:0]      o_rx_data,
   output logic            o_rx_last,
   output logic            o_rx_crc_ok
);
   typedef enum logic [2:0] {M_ADDR, M_FUNC, M_EA, M_EF, M_PASS, M_CLO,
                             M_CHI, M_DROP} mbs_mst_e;
   mbs_mst_e    state;
   logic [7:0]  addr;
   logic [7:0]  fcode;
   logic        short;
   logic [15:0] crc;
   logic [15:0] rx_crc;
   logic [15:0] next_rx_crc;
   logic        go;
   logic        take;

   assign o_tx_ready    = (state == M_ADDR) || (state == M_FUNC)
                          || (state == M_DROP)
                          || (state == M_PASS && lnk.m2s_ready);
   assign take          = i_tx_valid && o_tx_ready;
   assign lnk.m2s_valid = (state == M_EA) || (state == M_EF)
                          || (state == M_CLO) || (state == M_CHI)
                          || (state == M_PASS && i_tx_valid);
   always_comb begin
      unique case (state)
         M_EA:    lnk.m2s_data = addr;
         M_EF:    lnk.m2s_data = fcode;
         M_CLO:   lnk.m2s_data = crc[7:0];
         M_CHI:   lnk.m2s_data = crc[15:8];
         default: lnk.m2s_data = i_tx_data;
      endcase
   end
   assign lnk.m2s_last  = (state == M_CHI);
   assign go            = lnk.m2s_valid && lnk.m2s_ready;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         state        <= M_ADDR;
         addr         <= '0;
         fcode        <= '0;
         short        <= 1'b0;
         crc          <= mbs_pkg::CRC_INIT;
         o_tx_refused <= 1'b0;
      end else begin
         o_tx_refused <= 1'b0;
         if (go && state != M_CLO && state != M_CHI) begin
            crc <= mbs_pkg::crc_step(crc, lnk.m2s_data);
         end
         unique case (state)
            M_ADDR: if (take) begin
               addr  <= i_tx_data;
               state <= i_tx_last ? M_ADDR : M_FUNC;
            end
            M_FUNC: if (take) begin
               fcode <= i_tx_data;
               short <= i_tx_last;
               if (addr == mbs_pkg::BCAST_ADDR
                   && i_tx_data == mbs_pkg::FN_READ) begin
                  o_tx_refused <= 1'b1;
                  state        <= i_tx_last ? M_ADDR : M_DROP;
               end else begin
                  state <= M_EA;
               end
            end
            M_EA: if (go) state <= M_EF;
            M_EF: if (go) state <= short ? M_CLO : M_PASS;
            M_PASS: if (go && i_tx_last) state <= M_CLO;
            M_CLO: if (go) state <= M_CHI;
            M_CHI: if (go) begin
               crc   <= mbs_pkg::CRC_INIT;
               state <= M_ADDR;
            end
            M_DROP: if (take && i_tx_last) state <= M_ADDR;
            default: state <= M_ADDR;
         endcase
      end
   end

   // reply side never stalls; check residue at the last byte
   assign lnk.s2m_ready = 1'b1;
   assign next_rx_crc   = mbs_pkg::crc_step(rx_crc, lnk.s2m_data);

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         rx_crc      <= mbs_pkg::CRC_INIT;
         o_rx_valid  <= 1'b0;
         o_rx_data   <= '0;
         o_rx_last   <= 1'b0;
         o_rx_crc_ok <= 1'b0;
      end else begin
         o_rx_valid <= lnk.s2m_valid;
         o_rx_last  <= 1'b0;
         if (lnk.s2m_valid) begin
            o_rx_data <= lnk.s2m_data;
            o_rx_last <= lnk.s2m_last;
            if (lnk.s2m_last) begin
               rx_crc      <= mbs_pkg::CRC_INIT;
               o_rx_crc_ok <= (next_rx_crc == 16'h0000);
            end else begin
               rx_crc <= next_rx_crc;
            end
         end
      end
   end
endmodule // mbs_master

// >>> mbs_tbp.sv
// reference crc for the bench and the link checker
package mbs_tbp;
   function automatic logic [15:0] crc_b(input logic [15:0] c,
                                         input logic [7:0]  b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
      end
      return r;
   endfunction
endpackage

// >>> mbs_link_properties.sv
// link checker: crc trailers, broadcast silence and function echo
`timescale 1ns/100ps
module mbs_link_properties (
   // clock and reset
   input wire logic       i_sys_clk,
   input wire logic       i_srst,
   // link signals
   input wire logic       m2s_valid,
   input wire logic       m2s_ready,
   input wire logic [7:0] m2s_data,
   input wire logic       m2s_last,
   input wire logic       s2m_valid,
   input wire logic       s2m_ready,
   input wire logic [7:0] s2m_data,
   input wire logic       s2m_last
);
   logic [5:0]  m_idx;
   logic [5:0]  s_idx;
   logic [15:0] m_crc;
   logic [15:0] s_crc;
   logic [7:0]  m_addr;
   logic [7:0]  m_fn;
   logic        m_ok;
   logic        m_tk;
   logic        s_tk;

   assign m_tk = m2s_valid & m2s_ready;
   assign s_tk = s2m_valid & s2m_ready;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);

   // byte position and running crc, restarted after each last byte
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         m_idx <= 6'h00;
         s_idx <= 6'h00;
         m_crc <= 16'hffff;
         s_crc <= 16'hffff;
      end else begin
         if (m_tk) begin
            m_idx <= m2s_last ? 6'h00 : m_idx + 6'h01;
            m_crc <= m2s_last ? 16'hffff : mbs_tbp::crc_b(m_crc, m2s_data);
         end
         if (s_tk) begin
            s_idx <= s2m_last ? 6'h00 : s_idx + 6'h01;
            s_crc <= s2m_last ? 16'hffff : mbs_tbp::crc_b(s_crc, s2m_data);
         end
      end
   end

   // fields of the latest request, kept until the next one
   always_ff @(posedge i_sys_clk) begin
      if (m_tk && m_idx == 6'h00)
         m_addr <= m2s_data;
      if (m_tk && m_idx == 6'h01)
         m_fn <= m2s_data;
      if (i_srst)
         m_ok <= 1'b0;
      else if (m_tk && m2s_last)
         m_ok <= mbs_tbp::crc_b(m_crc, m2s_data) == 16'h0000;
   end

   chk_req_crc: assert property (
      m_tk && m2s_last |-> mbs_tbp::crc_b(m_crc, m2s_data) == 16'h0000)
      else $error("request trailer wrong");
   chk_reply_crc: assert property (
      s_tk && s2m_last |-> mbs_tbp::crc_b(s_crc, s2m_data) == 16'h0000)
      else $error("reply trailer wrong");
   chk_no_bcast_read: assert property (
      m_tk && m_idx == 6'h01 && m_addr == 8'h00 |-> m2s_data != 8'h03)
      else $error("broadcast read sent");
   chk_bcast_silent: assert property (
      s_tk && s_idx == 6'h00 |-> m_addr != 8'h00)
      else $error("reply to broadcast");
   chk_bad_crc_silent: assert property (
      s_tk && s_idx == 6'h00 |-> m_ok)
      else $error("reply to bad crc frame");
   chk_fn_echo: assert property (
      s_tk && s_idx == 6'h01 |-> s2m_data == m_fn
                                 || s2m_data == m_fn + 8'h80)
      else $error("function code not echoed");
   chk_bad_fn_err: assert property (
      s_tk && s_idx == 6'h01
      && !(m_fn inside {8'h03, 8'h06, 8'h08, 8'h10, 8'h46})
      |-> s2m_data == m_fn + 8'h80)
      else $error("unsupported code answered normally");
   chk_reply_burst: assert property (
      s_tk && !s2m_last |=> s2m_valid)
      else $error("gap inside reply");
endmodule // mbs_link_properties

// >>> tb_top.sv
// bench: both link ends, a faulty-master link, and rx fifo backpressure
`timescale 1ns/100ps
`define CHECK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("ERROR t=%0t got %0h exp %0h", $time, got, exp); \
      end \
   end

module tb_top;
   typedef logic [7:0] mbs_bytes_t[$];
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        tx_valid = 1'b0, tx_last = 1'b0;
   logic [7:0]  tx_data = 8'h00;
   logic        tx_ready, tx_refused, rx_valid, rx_last, rx_crc_ok;
   logic [7:0]  rx_data;
   logic        reg_req, reg_we, b_req;
   logic        reg_ack = 1'b0, reg_err = 1'b0;
   logic [7:0]  own_addr = 8'h11;
   logic [15:0] reg_addr, reg_wdata, reg_rdata = 16'h0000;
   logic [15:0] mem[0:15];
   logic [7:0]  codes[4] = '{8'h01, 8'h07, 8'h45, 8'h7f};
   int          wcnt = 0, refused = 0, b_hits = 0, fill = 0;
   int          num_errors = 0, comparisons = 0;
   mbs_bytes_t  rxq, bq, pkt, pk2;

   mbs_link_if lnk();
   mbs_link_if lnk_b();
   mbs_master u_mbs_master (.i_sys_clk(clk), .i_srst(rst), .lnk(lnk),
      .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_last(tx_last),
      .o_tx_ready(tx_ready), .o_tx_refused(tx_refused),
      .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_last(rx_last),
      .o_rx_crc_ok(rx_crc_ok));
   mbs_slave u_mbs_slave (.i_sys_clk(clk), .i_srst(rst), .lnk(lnk),
      .i_own_addr(own_addr), .o_reg_req(reg_req), .o_reg_we(reg_we),
      .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .i_reg_ack(reg_ack),
      .i_reg_err(reg_err), .i_reg_rdata(reg_rdata));
   // second slave faces the bench directly so frames can be corrupted
   mbs_slave u_mbs_slave_bad (.i_sys_clk(clk), .i_srst(rst), .lnk(lnk_b),
      .i_own_addr(own_addr), .o_reg_req(b_req), .o_reg_we(),
      .o_reg_addr(), .o_reg_wdata(), .i_reg_ack(b_req), .i_reg_err(1'b0),
      .i_reg_rdata(16'h0000));
   mbs_link_properties u_mbs_link_properties (.i_sys_clk(clk),
      .i_srst(rst), .m2s_valid(lnk.m2s_valid), .m2s_ready(lnk.m2s_ready),
      .m2s_data(lnk.m2s_data), .m2s_last(lnk.m2s_last),
      .s2m_valid(lnk.s2m_valid), .s2m_ready(lnk.s2m_ready),
      .s2m_data(lnk.s2m_data), .s2m_last(lnk.s2m_last));

   always #25 clk = ~clk;

   // monitors and a holding register store acking on the third cycle
   always @(posedge clk) begin
      if (rx_valid)
         rxq.push_back(rx_data);
      if (lnk_b.s2m_valid && lnk_b.s2m_ready)
         bq.push_back(lnk_b.s2m_data);
      if (tx_refused)
         refused++;
      if (b_req)
         b_hits++;
      reg_ack <= reg_req && !reg_ack && wcnt == 2;
      if (reg_req && !reg_ack)
         wcnt <= (wcnt == 2) ? 0 : wcnt + 1;
      if (reg_req && !reg_ack && wcnt == 2) begin
         reg_err <= reg_addr >= 16'h0040;
         reg_rdata <= mem[reg_addr[3:0]];
         if (reg_we && reg_addr < 16'h0040)
            mem[reg_addr[3:0]] <= reg_wdata;
      end
   end

   function automatic mbs_bytes_t with_crc(input mbs_bytes_t q);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i])
         c = mbs_tbp::crc_b(c, q[i]);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      return q;
   endfunction

   task automatic cmpq(input mbs_bytes_t got, input mbs_bytes_t exp);
      `CHECK(got.size(), exp.size())
      foreach (exp[i])
         if (i < got.size())
            `CHECK(got[i], exp[i])
   endtask

   task automatic xact(input mbs_bytes_t req, input mbs_bytes_t exp);
      rxq = {};
      foreach (req[i]) begin
         tx_valid <= 1'b1;
         tx_data <= req[i];
         tx_last <= (i == req.size() - 1);
         do @(negedge clk); while (tx_ready !== 1'b1);
         @(posedge clk);
      end
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      if (exp.size() != 0)
         exp = with_crc(exp);
      for (int n = 0; n < 150; n++) begin
         @(posedge clk);
         if (exp.size() != 0 && rxq.size() == exp.size())
            break;
      end
      repeat (3) @(posedge clk);
      cmpq(rxq, exp);
      if (exp.size() != 0)
         `CHECK(rx_crc_ok, 1'b1)
      $display("test done at %0t", $time);
   endtask

   task automatic raw(input mbs_bytes_t q);
      bq = {};
      foreach (q[i]) begin
         lnk_b.m2s_valid <= 1'b1;
         lnk_b.m2s_data <= q[i];
         lnk_b.m2s_last <= (i == q.size() - 1);
         do begin
            @(negedge clk);
            // fifo full behind a stalled reply: note fill, then release
            if (lnk_b.m2s_ready !== 1'b1 && lnk_b.s2m_ready !== 1'b1) begin
               fill = i;
               @(posedge clk);
               lnk_b.s2m_ready <= 1'b1;
            end
         end while (lnk_b.m2s_ready !== 1'b1);
         @(posedge clk);
      end
      lnk_b.m2s_valid <= 1'b0;
      lnk_b.m2s_last <= 1'b0;
      // released line must not keep showing the last byte
      lnk_b.m2s_data <= ~q[q.size() - 1];
      repeat (100) @(posedge clk);
      $display("raw test done at %0t", $time);
   endtask

   task automatic final_report;
      $display("comparisons %0d, errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #1000000;
      num_errors++;
      final_report();
   end

   initial begin
      lnk_b.m2s_valid = 1'b0;
      lnk_b.m2s_last = 1'b0;
      lnk_b.m2s_data = 8'h00;
      lnk_b.s2m_ready = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      pkt = '{8'h11, 8'h06, 8'h00, 8'h03, 8'h12, 8'h34};
      xact(pkt, pkt);
      xact('{8'h11, 8'h10, 8'h00, 8'h04, 8'h00, 8'h02, 8'h04, 8'haa, 8'hbb,
         8'hcc, 8'hdd}, '{8'h11, 8'h10, 8'h00, 8'h04, 8'h00, 8'h02});
      xact('{8'h11, 8'h03, 8'h00, 8'h03, 8'h00, 8'h03}, '{8'h11, 8'h03,
         8'h06, 8'h12, 8'h34, 8'haa, 8'hbb, 8'hcc, 8'hdd});
      pkt = '{8'h11, 8'h08, 8'h00, 8'h00, 8'hab, 8'hcd};
      xact(pkt, pkt);
      xact('{8'h11, 8'h46}, '{8'h11, 8'h46, 8'h00, 8'h03});
      foreach (codes[i])
         xact('{8'h11, codes[i]}, '{8'h11, codes[i] + 8'h80, 8'h01});
      xact('{8'h11, 8'h06, 8'h00, 8'h40, 8'h00, 8'h01},
         '{8'h11, 8'h86, 8'h04});
      xact('{8'h11, 8'h46}, '{8'h11, 8'h46, 8'h00, 8'h00});
      xact('{8'h00, 8'h06, 8'h00, 8'h07, 8'h55, 8'h66}, '{});
      xact('{8'h11, 8'h03, 8'h00, 8'h07, 8'h00, 8'h01},
         '{8'h11, 8'h03, 8'h02, 8'h55, 8'h66});
      xact('{8'h00, 8'h03, 8'h00, 8'h07, 8'h00, 8'h01}, '{});
      `CHECK(refused, 1)
      pkt = with_crc('{8'h11, 8'h08, 8'h00, 8'h00});
      pkt[4] = pkt[4] ^ 8'h01;
      raw(pkt);
      `CHECK(bq.size(), 0)
      raw(with_crc('{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}));
      `CHECK(bq.size() + b_hits, 0)
      pkt = with_crc('{8'h11, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02});
      raw(pkt);
      cmpq(bq, pkt);
      // hold the reply to the next frame back so the frame after it backs up the rx fifo
      lnk_b.s2m_ready <= 1'b0;
      pkt = with_crc('{8'h11, 8'h08, 8'h00, 8'h00});
      raw(pkt);
      pk2 = with_crc('{8'h11, 8'h08, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
         8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d});
      raw(pk2);
      `CHECK(fill, 16)
      cmpq(bq, {pkt, pk2});
      `CHECK(lnk_b.m2s_ready, 1'b1)
      $display("fifo test done at %0t", $time);
      final_report();
   end
endmodule // tb_top
